// >>> fts_pkg.sv
// Constants, register map and state type of the frame timing sequencer
`default_nettype none
package fts_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // System clock, carried as the system_clock_rate of the sequencer
  localparam int unsigned SYSTEM_CLOCK_RATE = 32'h01312D00;

  ////////////////////////////////////////////////////////////////////////////
  // APB byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SYNC_DLY = 8'h04;
  localparam logic [7:0] ADDR_SUBFRM = 8'h08;
  localparam logic [7:0] ADDR_QUAD_LEN = 8'h0C;
  localparam logic [7:0] ADDR_DUTY = 8'h10;
  localparam logic [7:0] ADDR_READOUT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_START_SEL_BIT = 1;
  localparam int CTRL_RESYNC_SEL_BIT = 2;
  localparam int CTRL_ALT_BIT = 3;
  localparam int CTRL_GROUP_BIT = 4;
  localparam int SUBFRM_BASE_LSB = 0;
  localparam int SUBFRM_SUPP_LSB = 8;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_SUPP_BIT = 1;
  localparam int STAT_QUAD_LSB = 2;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_SUB_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] SYNC_DLY_RST = 16'h0001;
  localparam logic [7:0] BASE_SUB_RST = 8'h10;
  localparam logic [7:0] SUPP_SUB_RST = 8'h04;
  localparam logic [15:0] QUAD_LEN_RST = 16'h30D4;
  localparam logic [5:0] DUTY_RST = 6'h0D;
  localparam logic [15:0] READOUT_PIX_RST = 16'h12C0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing counts in system clock cycles, and the index of the last quad
  localparam logic [31:0] RESET_CYCLES = 32'h000002D0;
  localparam logic [31:0] PREP_CYCLES = 32'h00000064;
  localparam logic [1:0] LAST_QUAD = 2'h3;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_SYNC, ST_RESET, ST_INTEG, ST_READOUT, ST_QUAD_DEAD, ST_FRAME_DEAD
  } fts_state_type;

endpackage
`default_nettype wire

// >>> fts_cfg_if.sv
// Configuration and status carrier between register file and sequencer
`default_nettype none
interface fts_cfg_if;
  logic tg_enable;
  logic ext_start_sel;
  logic resync_sel;
  logic frame_alternation_enable;
  logic group_dead;
  logic [15:0] sync_delay;
  logic [7:0] base_subframe_count;
  logic [7:0] supp_subframe_count;
  logic [15:0] quad_length_cycles;
  logic [5:0] duty;
  logic [15:0] readout_pix;
  fts_pkg::fts_state_type state;
  logic supp_frame;
  logic [1:0] quad_idx;
  logic [7:0] sub_idx;

  modport regs (
    output tg_enable, ext_start_sel, resync_sel, frame_alternation_enable, group_dead,
    output sync_delay, base_subframe_count, supp_subframe_count, quad_length_cycles, duty, readout_pix,
    input state, supp_frame, quad_idx, sub_idx
  );
  modport core (
    input tg_enable, ext_start_sel, resync_sel, frame_alternation_enable, group_dead,
    input sync_delay, base_subframe_count, supp_subframe_count, quad_length_cycles, duty, readout_pix,
    output state, supp_frame, quad_idx, sub_idx
  );
endinterface
`default_nettype wire

// >>> fts_apb_regs.sv
// APB register file of the frame timing sequencer
`default_nettype none
module fts_apb_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration and status
  fts_cfg_if.regs cfg
);
  logic [4:0] ctrl_reg;
  logic [15:0] sync_dly_reg;
  logic [7:0] base_sub_reg;
  logic [7:0] supp_sub_reg;
  logic [15:0] quad_len_reg;
  logic [5:0] duty_reg;
  logic [15:0] readout_reg;
  logic flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode; zero wait states, so every access ends in its first access cycle
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  wire hit = (paddr[1:0] == 2'h0) && (paddr <= fts_pkg::ADDR_STATUS);
  wire wr_quad = wr_en && (paddr == fts_pkg::ADDR_QUAD_LEN);
  wire [31:0] min_quad = fts_pkg::RESET_CYCLES + fts_pkg::PREP_CYCLES + {16'h0000, readout_reg};
  wire [31:0] status_word = {16'h0000, cfg.sub_idx, 1'b0, cfg.state, cfg.quad_idx, cfg.supp_frame, flag_reg};
  assign pready = 1'b1;
  assign pslverr = access & ~hit; // Unmapped word or misaligned address
  wire setup_rd = psel & ~penable & ~pwrite;
  wire [31:0] rd_mux = (paddr == fts_pkg::ADDR_CTRL) ? {27'h0000000, ctrl_reg} :
    (paddr == fts_pkg::ADDR_SYNC_DLY) ? {16'h0000, sync_dly_reg} :
    (paddr == fts_pkg::ADDR_SUBFRM) ? {16'h0000, supp_sub_reg, base_sub_reg} :
    (paddr == fts_pkg::ADDR_QUAD_LEN) ? {16'h0000, quad_len_reg} :
    (paddr == fts_pkg::ADDR_DUTY) ? {26'h0000000, duty_reg} :
    (paddr == fts_pkg::ADDR_READOUT) ? {16'h0000, readout_reg} :
    (paddr == fts_pkg::ADDR_STATUS) ? status_word : 32'h00000000;

  // Read data caught at the end of setup: leaves a flop, still no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= setup_rd ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers; the status word is read-only and ignores writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= fts_pkg::CTRL_RST;
      sync_dly_reg <= fts_pkg::SYNC_DLY_RST;
      base_sub_reg <= fts_pkg::BASE_SUB_RST;
      supp_sub_reg <= fts_pkg::SUPP_SUB_RST;
      quad_len_reg <= fts_pkg::QUAD_LEN_RST;
      duty_reg <= fts_pkg::DUTY_RST;
      readout_reg <= fts_pkg::READOUT_PIX_RST;
    end else if (wr_en) begin
      if (paddr == fts_pkg::ADDR_CTRL) ctrl_reg <= pwdata[4:0];
      if (paddr == fts_pkg::ADDR_SYNC_DLY) sync_dly_reg <= pwdata[15:0];
      if (paddr == fts_pkg::ADDR_SUBFRM) begin
        base_sub_reg <= pwdata[fts_pkg::SUBFRM_BASE_LSB +: 8];
        supp_sub_reg <= pwdata[fts_pkg::SUBFRM_SUPP_LSB +: 8];
      end
      if (wr_quad) quad_len_reg <= pwdata[15:0];
      if (paddr == fts_pkg::ADDR_DUTY) duty_reg <= pwdata[5:0];
      if (paddr == fts_pkg::ADDR_READOUT) readout_reg <= pwdata[15:0];
    end
  end

  // Flag judged against the quad length just written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (wr_quad) begin
      flag_reg <= ({16'h0000, pwdata[15:0]} < min_quad);
    end
  end

  a_flag_on_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_quad |=> flag_reg == ($past(pwdata[15:0]) < $past(min_quad[15:0]) || $past(min_quad[31:16]) != 16'h0000))
    else $error("quad length flag does not match the written value");

  assign cfg.tg_enable = ctrl_reg[fts_pkg::CTRL_EN_BIT];
  assign cfg.ext_start_sel = ctrl_reg[fts_pkg::CTRL_START_SEL_BIT];
  assign cfg.resync_sel = ctrl_reg[fts_pkg::CTRL_RESYNC_SEL_BIT];
  assign cfg.frame_alternation_enable = ctrl_reg[fts_pkg::CTRL_ALT_BIT];
  assign cfg.group_dead = ctrl_reg[fts_pkg::CTRL_GROUP_BIT];
  assign cfg.sync_delay = sync_dly_reg;
  assign cfg.base_subframe_count = base_sub_reg;
  assign cfg.supp_subframe_count = supp_sub_reg;
  assign cfg.quad_length_cycles = quad_len_reg;
  assign cfg.duty = duty_reg;
  assign cfg.readout_pix = readout_reg;
endmodule
`default_nettype wire

// >>> fts_sync_delay.sv
// Frame sync pulse recognition and start delay
`default_nettype none
module fts_sync_delay (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and control
  input wire logic frame_sync_input,
  input wire logic armed,
  input wire logic [15:0] sync_delay,
  // Delayed start
  output logic sync_go
);
  logic prev_reg;
  logic seen_reg;
  logic busy_reg;
  logic [15:0] dly_cnt_reg;
  logic [15:0] since_reg;

  ////////////////////////////////////////////////////////////////////////////
  // A pulse counts on its second high cycle, once per pulse
  wire two_high = frame_sync_input & prev_reg;
  wire recog = two_high & ~seen_reg & armed & ~busy_reg;
  wire [15:0] eff_delay = (sync_delay == 16'h0000) ? 16'h0001 : sync_delay; // Guard against a zero setting
  assign sync_go = busy_reg && (dly_cnt_reg == 16'h0000) && armed;

  // Delay counter runs from recognition to the start pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
      seen_reg <= 1'b0;
      busy_reg <= 1'b0;
      dly_cnt_reg <= 16'h0000;
      since_reg <= 16'h0000;
    end else begin
      prev_reg <= frame_sync_input;
      seen_reg <= frame_sync_input & (seen_reg | prev_reg);
      since_reg <= recog ? 16'h0001 : since_reg + 16'h0001;
      if (!armed || sync_go) begin
        busy_reg <= 1'b0;
      end else if (recog) begin
        busy_reg <= 1'b1;
        dly_cnt_reg <= eff_delay - 16'h0001;
      end else if (busy_reg) begin
        dly_cnt_reg <= dly_cnt_reg - 16'h0001;
      end
    end
  end

  a_sync_delay_len: assert property (@(posedge pclk) disable iff (!presetn)
    sync_go |-> since_reg == eff_delay)
    else $error("frame start not at the programmed delay after the sync pulse");

  a_two_high_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy_reg) |-> $past(frame_sync_input) && $past(frame_sync_input, 2))
    else $error("sync pulse taken before two high cycles");
endmodule
`default_nettype wire

// >>> fts_top.sv
// Frame timing sequencer: frame, sub-frame, quad and stage sequencing
//
// Summary of operation
// - Enable bit low keeps sequencing idle.
// - External start select: frames wait for sync.
// - Resync select: realign to sync, else free-run.
// - Both selects set: resync behaviour wins.
// - Frame starts programmed cycles after sync.
// - External start ignores pulses during a frame.
// - Resync pulse aborts and restarts current frame.
// - Always four quads per sub-frame.
// - Alternation makes every other frame supplementary.
// - Base frames use base sub-frame count.
// - Supplementary frames use supplementary sub-frame count.
// - Ungrouped quads last programmed quad length, or reset, integration and readout if those run longer.
// - Read-only flag: quad length too short.
// - Dead time per quad or lumped per frame.
// - Quad dead time from length, duty, reset, readout.
// - Lumped dead time: sub-frames times four quads.
// - Reset stage lasts exactly 720 cycles.
// - Stages: reset, integration, readout, dead.
// - Readout includes 100 cycle preparation period.
`default_nettype none
module fts_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame sync pin
  input wire logic frame_sync_input,
  // Sequencing outputs
  output fts_pkg::fts_state_type stage_state,
  output logic frame_start_pulse,
  output logic supp_frame,
  output logic [1:0] quad_index,
  output logic [7:0] subframe_index,
  output logic adc_low_power
);
  fts_cfg_if cfg_bus();

  fts_pkg::fts_state_type state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [1:0] quad_reg, quad_next;
  logic [7:0] sub_reg, sub_next;
  logic supp_reg, supp_next;
  logic fstart_reg, fstart_next;
  logic low_power_reg;
  logic [31:0] run_reg;
  logic sync_go;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and sync pulse handling
  fts_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg_bus.regs)
  );

  // Resync takes precedence when both selects are set
  wire resync_mode = cfg_bus.resync_sel;
  wire slave_mode = cfg_bus.ext_start_sel & ~cfg_bus.resync_sel;
  wire running = (state_reg != fts_pkg::ST_IDLE) && (state_reg != fts_pkg::ST_WAIT_SYNC);
  // External start only listens between frames, so mid-frame pulses are dropped
  wire armed = cfg_bus.tg_enable & (resync_mode | (slave_mode & (state_reg == fts_pkg::ST_WAIT_SYNC)));
  wire resync_go = resync_mode & sync_go & running;

  fts_sync_delay u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .frame_sync_input(frame_sync_input),
    .armed(armed),
    .sync_delay(cfg_bus.sync_delay),
    .sync_go(sync_go)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Stage lengths; duty and integration length are each clamped to at least one so integration never vanishes
  wire [5:0] duty_eff = (cfg_bus.duty == 6'h00) ? 6'h01 : cfg_bus.duty;
  wire [21:0] integ_prod = 22'(cfg_bus.quad_length_cycles) * 22'(duty_eff);
  wire [31:0] integ_len = (integ_prod[21:6] == 16'h0000) ? 32'h00000001 : {16'h0000, integ_prod[21:6]};
  wire [31:0] readout_len = fts_pkg::PREP_CYCLES + {16'h0000, cfg_bus.readout_pix};
  wire [31:0] busy_len = fts_pkg::RESET_CYCLES + integ_len + readout_len;
  wire [31:0] quad_len = {16'h0000, cfg_bus.quad_length_cycles};
  // Too short a quad leaves no dead time rather than a negative one
  wire [31:0] quad_dead = (quad_len > busy_len) ? quad_len - busy_len : 32'h00000000;
  wire [7:0] cur_sub = supp_reg ? cfg_bus.supp_subframe_count : cfg_bus.base_subframe_count;
  wire [31:0] frame_dead = {22'h000000, cur_sub, 2'h0} * quad_dead;
  wire stage_done = (cnt_reg == 32'h00000000);
  wire last_quad = (quad_reg == fts_pkg::LAST_QUAD);
  wire last_sub = (sub_reg == cur_sub - 8'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    logic quad_end;
    logic frame_end;
    logic start;
    quad_end = 1'b0;
    frame_end = 1'b0;
    start = 1'b0;
    state_next = state_reg;
    cnt_next = stage_done ? cnt_reg : cnt_reg - 32'h00000001;
    quad_next = quad_reg;
    sub_next = sub_reg;
    supp_next = supp_reg;
    fstart_next = 1'b0;
    if (!cfg_bus.tg_enable) begin
      state_next = fts_pkg::ST_IDLE;
      cnt_next = 32'h00000000;
      quad_next = 2'h0;
      sub_next = 8'h00;
      supp_next = 1'b0;
    end else if (resync_go) begin
      start = 1'b1;
    end else begin
      case (state_reg)
        fts_pkg::ST_IDLE: begin
          if (slave_mode) state_next = fts_pkg::ST_WAIT_SYNC;
          else start = 1'b1;
        end
        fts_pkg::ST_WAIT_SYNC: begin
          if (sync_go || !slave_mode) start = 1'b1;
        end
        fts_pkg::ST_RESET: begin
          if (stage_done) begin
            state_next = fts_pkg::ST_INTEG;
            cnt_next = integ_len - 32'h00000001;
          end
        end
        fts_pkg::ST_INTEG: begin
          if (stage_done) begin
            state_next = fts_pkg::ST_READOUT;
            cnt_next = readout_len - 32'h00000001;
          end
        end
        fts_pkg::ST_READOUT: begin
          if (stage_done) begin
            if (!cfg_bus.group_dead && quad_dead != 32'h00000000) begin
              state_next = fts_pkg::ST_QUAD_DEAD;
              cnt_next = quad_dead - 32'h00000001;
            end else begin
              quad_end = 1'b1;
            end
          end
        end
        fts_pkg::ST_QUAD_DEAD: begin
          if (stage_done) quad_end = 1'b1;
        end
        fts_pkg::ST_FRAME_DEAD: begin
          if (stage_done) frame_end = 1'b1;
        end
        default: begin
          state_next = fts_pkg::ST_IDLE;
        end
      endcase
    end
    // Quad wrap into sub-frame and frame
    if (quad_end) begin
      if (last_quad && last_sub) begin
        if (cfg_bus.group_dead && frame_dead != 32'h00000000) begin
          state_next = fts_pkg::ST_FRAME_DEAD;
          cnt_next = frame_dead - 32'h00000001;
        end else begin
          frame_end = 1'b1;
        end
      end else begin
        quad_next = quad_reg + 2'h1;
        if (last_quad) sub_next = sub_reg + 8'h01;
        state_next = fts_pkg::ST_RESET;
        cnt_next = fts_pkg::RESET_CYCLES - 32'h00000001;
      end
    end
    // Completed frame flips the kind when alternation is on
    if (frame_end) begin
      supp_next = cfg_bus.frame_alternation_enable ? ~supp_reg : 1'b0;
      quad_next = 2'h0;
      sub_next = 8'h00;
      if (slave_mode) state_next = fts_pkg::ST_WAIT_SYNC;
      else start = 1'b1;
    end
    // Fresh frame; an aborted frame keeps its kind
    if (start) begin
      state_next = fts_pkg::ST_RESET;
      cnt_next = fts_pkg::RESET_CYCLES - 32'h00000001;
      quad_next = 2'h0;
      sub_next = 8'h00;
      fstart_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= fts_pkg::ST_IDLE;
      cnt_reg <= 32'h00000000;
      quad_reg <= 2'h0;
      sub_reg <= 8'h00;
      supp_reg <= 1'b0;
      fstart_reg <= 1'b0;
      low_power_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      quad_reg <= quad_next;
      sub_reg <= sub_next;
      supp_reg <= supp_next;
      fstart_reg <= fstart_next;
      low_power_reg <= (state_next == fts_pkg::ST_QUAD_DEAD) || (state_next == fts_pkg::ST_FRAME_DEAD);
    end
  end

  // Cycles spent in the current stage, for the checks below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 32'h00000000;
    end else begin
      run_reg <= (state_next != state_reg || fstart_next) ? 32'h00000000 : run_reg + 32'h00000001;
    end
  end

  assign stage_state = state_reg;
  assign frame_start_pulse = fstart_reg;
  assign supp_frame = supp_reg;
  assign quad_index = quad_reg;
  assign subframe_index = sub_reg;
  assign adc_low_power = low_power_reg;
  assign cfg_bus.state = state_reg;
  assign cfg_bus.supp_frame = supp_reg;
  assign cfg_bus.quad_idx = quad_reg;
  assign cfg_bus.sub_idx = sub_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_idle_when_off: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_bus.tg_enable |=> state_reg == fts_pkg::ST_IDLE && quad_reg == 2'h0 && sub_reg == 8'h00 && !supp_reg)
    else $error("sequencer not idle while disabled");

  a_reset_stage_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == fts_pkg::ST_RESET && state_next == fts_pkg::ST_INTEG) |-> run_reg == fts_pkg::RESET_CYCLES - 32'h00000001)
    else $error("reset stage not 720 cycles");

  a_readout_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == fts_pkg::ST_READOUT && state_next != fts_pkg::ST_READOUT && cfg_bus.tg_enable && !resync_go
     && $stable(cfg_bus.readout_pix)) |-> run_reg == readout_len - 32'h00000001)
    else $error("readout stage length wrong");

  a_four_quads: assert property (@(posedge pclk) disable iff (!presetn)
    (sub_next != sub_reg && sub_next != 8'h00) |-> quad_reg == 2'h3 ##1 quad_reg == 2'h0)
    else $error("sub-frame advanced before the fourth quad");

  a_slave_waits: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == fts_pkg::ST_WAIT_SYNC && slave_mode && !sync_go && cfg_bus.tg_enable)
      |=> state_reg == fts_pkg::ST_WAIT_SYNC && !frame_start_pulse)
    else $error("external start frame began without a sync pulse");

  a_slave_ignores: assert property (@(posedge pclk) disable iff (!presetn)
    (slave_mode && running) |-> !sync_go)
    else $error("sync pulse accepted during a frame");

  a_resync_abort: assert property (@(posedge pclk) disable iff (!presetn)
    (resync_go && cfg_bus.tg_enable) |=> state_reg == fts_pkg::ST_RESET && quad_reg == 2'h0
      && sub_reg == 8'h00 && frame_start_pulse)
    else $error("resync pulse did not restart the frame");

  a_alt_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (fstart_next && !resync_go && running && cfg_bus.tg_enable)
      |=> supp_reg == ($past(cfg_bus.frame_alternation_enable) ? !$past(supp_reg) : 1'b0))
    else $error("frame kind did not alternate");

  a_no_quad_dead_grouped: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_reg == fts_pkg::ST_QUAD_DEAD) |-> !$past(cfg_bus.group_dead))
    else $error("quad dead time inserted in grouped operation");

  a_low_power_dead: assert property (@(posedge pclk) disable iff (!presetn)
    low_power_reg == (state_reg == fts_pkg::ST_QUAD_DEAD || state_reg == fts_pkg::ST_FRAME_DEAD))
    else $error("converter low-power level disagrees with the stage");

  a_quad_dead_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == fts_pkg::ST_QUAD_DEAD && state_next != fts_pkg::ST_QUAD_DEAD && cfg_bus.tg_enable && !resync_go
     && $stable(quad_dead)) |-> run_reg == quad_dead - 32'h00000001)
    else $error("quad dead time length wrong");

  a_frame_dead_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == fts_pkg::ST_FRAME_DEAD && state_next != fts_pkg::ST_FRAME_DEAD && cfg_bus.tg_enable && !resync_go
     && $stable(frame_dead)) |-> run_reg == frame_dead - 32'h00000001)
    else $error("frame dead time length wrong");
endmodule
`default_nettype wire

// >>> fts_top_end_marker_unused.sv
// Spare source file, holds no logic of the sequencer
`default_nettype none
`default_nettype wire

// >>> fts_sync_src.sv
// Frame sync pulse source standing at the far side of the pin
`default_nettype none
module fts_sync_src (
  // Clock
  input wire logic pclk,
  // Frame sync pin
  output logic frame_sync_input
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin rests low between pulses
  initial frame_sync_input = 1'b0;
  // Active-high pulse held for whole cycles
  task automatic pulse(input int w);
    frame_sync_input <= 1'b1;
    repeat (w) @(posedge pclk);
    frame_sync_input <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the frame timing sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire logic frame_sync_input;
  fts_pkg::fts_state_type stage_state;
  logic frame_start_pulse, supp_frame, adc_low_power;
  logic [1:0] quad_index;
  logic [7:0] subframe_index;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  fts_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_sync_input(frame_sync_input), .stage_state(stage_state), .frame_start_pulse(frame_start_pulse),
    .supp_frame(supp_frame), .quad_index(quad_index), .subframe_index(subframe_index),
    .adc_low_power(adc_low_power));
  fts_sync_src src (.pclk(pclk), .frame_sync_input(frame_sync_input));
  // 20 MHz clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////
  // Mismatch report and tally
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; idle edge first so no signal is set twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Edges until a frame start shows, bounded
  task automatic wait_start(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (frame_start_pulse !== 1'b1 && n < lim);
  endtask
  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  // Watchdog, well above the 60k cycles the tests take
  initial begin
    #4_000_000;
    error_cnt++;
    give_verdict();
  end
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(fts_pkg::ADDR_CTRL, 32'h0);
    rd_chk(fts_pkg::ADDR_SYNC_DLY, 32'h1);
    rd_chk(fts_pkg::ADDR_SUBFRM, 32'h410);
    rd_chk(fts_pkg::ADDR_QUAD_LEN, 32'h30D4);
    rd_chk(fts_pkg::ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check(perr, 1'b1);
    // Too-short quad sets the flag, a sane one clears it
    apb(1'b1, fts_pkg::ADDR_QUAD_LEN, 32'h100);
    rd_chk(fts_pkg::ADDR_STATUS, 32'h1);
    apb(1'b1, fts_pkg::ADDR_QUAD_LEN, 32'h30D4);
    rd_chk(fts_pkg::ADDR_STATUS, 32'h0);
    // Master run with default timing
    apb(1'b1, fts_pkg::ADDR_CTRL, 32'h1);
    wait_start(10);
    check(n, 1);
    check(stage_state, fts_pkg::ST_RESET);
    repeat (720) @(posedge pclk);
    #1;
    check(stage_state, fts_pkg::ST_INTEG);
    repeat (11780) @(posedge pclk);
    #1;
    check(quad_index, 2'h1);
    repeat (8159) @(posedge pclk);
    #1;
    check(adc_low_power, 1'b1);
    check(stage_state, fts_pkg::ST_QUAD_DEAD);
    repeat (29341) @(posedge pclk);
    #1;
    check({subframe_index, quad_index}, 10'h004);
    apb(1'b1, fts_pkg::ADDR_CTRL, 32'h0);
    @(posedge pclk);
    #1;
    check(stage_state, fts_pkg::ST_IDLE);
    check({subframe_index, quad_index}, 10'h0);
    // External start with a delay of three
    apb(1'b1, fts_pkg::ADDR_SYNC_DLY, 32'h3);
    apb(1'b1, fts_pkg::ADDR_CTRL, 32'h3);
    repeat (3) @(posedge pclk);
    check(stage_state, fts_pkg::ST_WAIT_SYNC);
    fork
      src.pulse(2);
    join_none
    wait_start(20);
    check(n, 5);
    @(posedge pclk);
    fork
      src.pulse(2);
    join_none
    wait_start(30);
    check(n, 30);
    // Both selects: a pulse mid-frame restarts it
    apb(1'b1, fts_pkg::ADDR_CTRL, 32'h7);
    fork
      src.pulse(2);
    join_none
    wait_start(20);
    check(n, 5);
    // Short grouped frames with alternation, one sub-frame of each kind
    apb(1'b1, fts_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, fts_pkg::ADDR_SUBFRM, 32'h101);
    apb(1'b1, fts_pkg::ADDR_READOUT, 32'h0);
    apb(1'b1, fts_pkg::ADDR_QUAD_LEN, 32'h44C);
    apb(1'b1, fts_pkg::ADDR_CTRL, 32'h19);
    wait_start(10);
    check(supp_frame, 1'b0);
    repeat (4172) @(posedge pclk);
    #1;
    check(stage_state, fts_pkg::ST_FRAME_DEAD);
    check(adc_low_power, 1'b1);
    wait_start(300);
    check(n, 228);
    check(supp_frame, 1'b1);
    wait_start(5000);
    check(n, 4400);
    check(supp_frame, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
